// ===== hdl/cbsc_params.svh
`ifndef CBSC_PARAMS_SVH
`define CBSC_PARAMS_SVH
// How it works
// - status lines show 0000 internal, 0001 refresh, 0010 normal I/O, 0011 special I/O
// - acknowledge codes: 0101 unmaskable, 0110 plain, 0111 vectored; 0100 reserved
// - operand memory cycles show 1000, stack memory cycles 1001
// - first fetch word shows 1101, later fetch words 1100
// - low wait input stretches a transfer until sampled high
// - mode output is high in normal mode, low in system mode
// - memory request is low only during memory and refresh cycles
// - bus request passes a two-stage synchroniser before use
// - on grant, grant goes low and all bus lines float
// - after request release, grant goes high later and the bus is retaken
// - falling edge on unmaskable input is the top-priority interrupt request; bus request ranks above it
// - low vectored input honoured only with its enable bit set
// - low plain input honoured only with its enable bit set, lowest-priority interrupt, above pending commands
// - low reset starts the reset sequence
// - low single-step input lets one instruction run per step
// - sixteen word registers with byte, pair and quad views
// - implicit stack pointer banked by mode; any register but zero explicit
// - control word holds system mode and the two interrupt enables
// - control word holds carry, zero, sign, parity/overflow, decimal and half carry
// - every machine cycle opens with a low address strobe pulse
// - bus granted only at machine cycle boundaries
// - wait ignored in internal and refresh cycles
// - every I/O cycle has one automatic wait state first

// status codes
`define CBSC_ST_INTERNAL   4'h0
`define CBSC_ST_REFRESH    4'h1
`define CBSC_ST_IO_NORMAL  4'h2
`define CBSC_ST_IO_SPECIAL 4'h3
`define CBSC_ST_ACK_UNMASK 4'h5
`define CBSC_ST_ACK_PLAIN  4'h6
`define CBSC_ST_ACK_VECT   4'h7
`define CBSC_ST_MEM_OPND   4'h8
`define CBSC_ST_MEM_STACK  4'h9
`define CBSC_ST_FETCH_NEXT 4'hC
`define CBSC_ST_FETCH_1ST  4'hD

// flag_control_word bit positions
`define CBSC_FCW_SYS   14
`define CBSC_FCW_VIE   12
`define CBSC_FCW_PIE   11
`define CBSC_FCW_C     7
`define CBSC_FCW_Z     6
`define CBSC_FCW_S     5
`define CBSC_FCW_PV    4
`define CBSC_FCW_DA    3
`define CBSC_FCW_H     2
`define CBSC_FCW_RESET 16'h4000
`define CBSC_FCW_MASK  16'h58FC

// command register fields
`define CBSC_CMD_CODE_LSB 0
`define CBSC_CMD_READ     4
`define CBSC_CMD_BYTE     5
`define CBSC_CMD_SP_LSB   8

// register byte addresses
`define CBSC_A_FCW     12'h000
`define CBSC_A_CMD     12'h004
`define CBSC_A_ADDR    12'h008
`define CBSC_A_WDATA   12'h00C
`define CBSC_A_RDATA   12'h010
`define CBSC_A_ACKVEC  12'h014
`define CBSC_A_SYS_SP  12'h080
`define CBSC_A_NORM_SP 12'h084
`define CBSC_R_WORD    6'h01
`define CBSC_R_BYTE    6'h03
`define CBSC_R_PAIR    7'h08
`define CBSC_R_QUAD    7'h0A
`endif

// ===== hdl/cbsc_pkg.sv
`include "cbsc_params.svh"
package cbsc_pkg;
    typedef enum logic [2:0] {CBSC_IDLE, CBSC_T1, CBSC_T2, CBSC_TWA, CBSC_TW, CBSC_T3,
                              CBSC_GRANT, CBSC_RELEASE} cbsc_state_t;

    typedef struct packed {
        cbsc_state_t            st;
        logic [3:0]             cmd_code;
        logic                   cmd_read;
        logic                   cmd_byte;
        logic                   cmd_pend;
        logic                   cmd_err;
        logic                   cyc_ack;
        logic [15:0]            addr;
        logic [15:0]            wdata;
        logic [15:0]            rdata;
        logic [15:0]            ack_vec;
        logic [15:0]            flag_control_word;
        logic [15:0][15:0]      gpr;
        logic [15:0]            sys_sp;
        logic [3:0]             sp_sel;
        logic                   brq_s1;
        logic                   brq_s2;
        logic                   nmi_prev;
        logic                   nmi_pend;
        logic                   step_prev;
        logic                   step_tok;
        logic [3:0]             status;
        logic                   as_n;
        logic                   ds_n;
        logic                   memory_request_n_n;
        logic                   mode;
        logic                   bw;
        logic                   dir;
        logic [15:0]            ad_out;
        logic                   ad_oe;
        logic                   ctl_oe;
        logic                   grant_n;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } cbsc_state_s_t;

    // memory-directed codes, refresh included
    function automatic logic cbsc_is_mem(input logic [3:0] c);
        return c[3] || (c == `CBSC_ST_REFRESH);
    endfunction

    function automatic logic cbsc_is_reserved(input logic [3:0] c);
        return (c == 4'h4) || (c == 4'hA) || (c == 4'hB) || (c == 4'hE) || (c == 4'hF);
    endfunction
endpackage

// ===== hdl/cbsc_core.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "cbsc_params.svh"
module cbsc_core
    import cbsc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wait_n,
    input  wire logic        bus_request_n,
    input  wire logic        unmaskable_irq_n,
    input  wire logic        vectored_irq_n,
    input  wire logic        plain_irq_n,
    input  wire logic        single_step_n,
    input  wire logic [15:0] addr_data_in,
    output logic      [15:0] addr_data_out,
    output logic             addr_data_oe,
    output logic             bus_ctl_oe,
    output logic      [3:0]  status_code,
    output logic             addr_strobe_n,
    output logic             data_strobe_n,
    output logic             memory_request_n,
    output logic             mode_indicator,
    output logic             byte_word_sel,
    output logic             direction,
    output logic             bus_grant_n
);
    cbsc_state_s_t r;
    cbsc_state_s_t n;

    // ==========================================================
    // helpers
    // ==========================================================
    // mode-banked view of word register i
    function automatic logic [15:0] word_rd(input cbsc_state_s_t s, input logic [3:0] i);
        if (i == 4'hF && s.flag_control_word[`CBSC_FCW_SYS]) begin
            return s.sys_sp;
        end
        return s.gpr[i];
    endfunction

    logic       nmi_edge;
    logic       is_io;
    logic       no_wait;
    logic [3:0] wi;
    logic [3:0] bi;
    logic [2:0] pk;
    logic [1:0] qk;

    // ==========================================================
    // next-state logic
    // ==========================================================
    // register views, bus engine, synchronisers
    always_comb begin
        n        = r;
        n.pready = 1'b0;
        wi       = paddr[5:2];
        bi       = {1'b0, paddr[5:3]};
        pk       = paddr[4:2];
        qk       = paddr[4:3];
        is_io    = (r.cmd_code == `CBSC_ST_IO_NORMAL) || (r.cmd_code == `CBSC_ST_IO_SPECIAL);
        no_wait  = (r.cmd_code == `CBSC_ST_INTERNAL) || (r.cmd_code == `CBSC_ST_REFRESH);
        // two-stage bus request synchroniser
        n.brq_s1 = bus_request_n;
        n.brq_s2 = r.brq_s1;
        nmi_edge = r.nmi_prev && !unmaskable_irq_n;
        n.nmi_prev = unmaskable_irq_n;
        if (nmi_edge) begin
            n.nmi_pend = 1'b1;
        end
        n.step_prev = single_step_n;
        if (r.step_prev && !single_step_n) begin
            n.step_tok = 1'b1;
        end
        n.mode = !r.flag_control_word[`CBSC_FCW_SYS];

        // apb setup: decode and prepare answer for the access phase
        if (psel && !penable) begin
            n.pready  = 1'b1;
            n.pslverr = 1'b0;
            n.prdata  = 32'h0000_0000;
            if (paddr[1:0] != 2'b00) begin
                n.pslverr = 1'b1;
            end else if (paddr == `CBSC_A_FCW) begin
                n.prdata[15:0] = r.flag_control_word;
            end else if (paddr == `CBSC_A_CMD) begin
                n.prdata[3:0] = {r.st == CBSC_GRANT, r.cmd_err, r.cmd_pend, r.nmi_pend};
                n.pslverr = pwrite && r.cmd_pend;
            end else if (paddr == `CBSC_A_ADDR) begin
                n.prdata[15:0] = r.addr;
            end else if (paddr == `CBSC_A_WDATA) begin
                n.prdata[15:0] = r.wdata;
            end else if (paddr == `CBSC_A_RDATA) begin
                n.prdata[15:0] = r.rdata;
            end else if (paddr == `CBSC_A_ACKVEC) begin
                n.prdata[15:0] = r.ack_vec;
            end else if (paddr == `CBSC_A_SYS_SP) begin
                n.prdata[15:0] = r.sys_sp;
            end else if (paddr == `CBSC_A_NORM_SP) begin
                n.prdata[15:0] = r.gpr[15];
            end else if (paddr[11:6] == `CBSC_R_WORD) begin
                n.prdata[15:0] = word_rd(r, wi);
            end else if (paddr[11:6] == `CBSC_R_BYTE) begin
                // even byte index is the high half of its word
                n.prdata[7:0] = wi[0] ? r.gpr[bi][7:0] : r.gpr[bi][15:8];
            end else if (paddr[11:5] == `CBSC_R_PAIR && !pwrite) begin
                n.prdata = {word_rd(r, {pk, 1'b0}), word_rd(r, {pk, 1'b1})};
            end else if (paddr[11:5] == `CBSC_R_QUAD && !pwrite) begin
                if (paddr[2]) begin
                    n.prdata = {word_rd(r, {qk, 2'd0}), word_rd(r, {qk, 2'd1})};
                end else begin
                    n.prdata = {word_rd(r, {qk, 2'd2}), word_rd(r, {qk, 2'd3})};
                end
            end else begin
                n.pslverr = 1'b1;
            end
        end

        // apb access: writes take effect at the completing edge
        if (psel && penable && r.pready && pwrite && !r.pslverr) begin
            if (paddr == `CBSC_A_FCW) begin
                n.flag_control_word = pwdata[15:0] & `CBSC_FCW_MASK;
            end else if (paddr == `CBSC_A_CMD) begin
                n.cmd_code = pwdata[`CBSC_CMD_CODE_LSB +: 4];
                n.cmd_read = pwdata[`CBSC_CMD_READ];
                n.cmd_byte = pwdata[`CBSC_CMD_BYTE];
                n.sp_sel   = pwdata[`CBSC_CMD_SP_LSB +: 4];
                // reserved codes are refused, never issued
                n.cmd_err  = cbsc_is_reserved(pwdata[3:0]);
                n.cmd_pend = !cbsc_is_reserved(pwdata[3:0]);
            end else if (paddr == `CBSC_A_ADDR) begin
                n.addr = pwdata[15:0];
            end else if (paddr == `CBSC_A_WDATA) begin
                n.wdata = pwdata[15:0];
            end else if (paddr == `CBSC_A_SYS_SP) begin
                n.sys_sp = pwdata[15:0];
            end else if (paddr == `CBSC_A_NORM_SP) begin
                n.gpr[15] = pwdata[15:0];
            end else if (paddr[11:6] == `CBSC_R_WORD) begin
                if (wi == 4'hF && r.flag_control_word[`CBSC_FCW_SYS]) begin
                    n.sys_sp = pwdata[15:0];
                end else begin
                    n.gpr[wi] = pwdata[15:0];
                end
            end else if (paddr[11:6] == `CBSC_R_BYTE) begin
                if (wi[0]) begin
                    n.gpr[bi][7:0] = pwdata[7:0];
                end else begin
                    n.gpr[bi][15:8] = pwdata[7:0];
                end
            end
        end

        // bus cycle engine
        unique case (r.st)
            CBSC_IDLE: begin
                n.as_n    = 1'b1;
                n.ds_n    = 1'b1;
                n.memory_request_n_n  = 1'b1;
                n.ctl_oe  = 1'b1;
                n.cyc_ack = 1'b0;
                if (!r.brq_s2) begin
                    // only here, between cycles, is the bus handed over
                    n.st      = CBSC_GRANT;
                    n.grant_n = 1'b0;
                    n.ctl_oe  = 1'b0;
                    n.ad_oe   = 1'b0;
                end else if (r.nmi_pend || (r.flag_control_word[`CBSC_FCW_VIE] && !vectored_irq_n)
                             || (r.flag_control_word[`CBSC_FCW_PIE] && !plain_irq_n)) begin
                    n.st      = CBSC_T1;
                    n.cyc_ack = 1'b1;
                    n.as_n    = 1'b0;
                    n.memory_request_n_n  = 1'b1;
                    n.dir     = 1'b1;
                    n.bw      = 1'b0;
                    n.ad_out  = r.addr;
                    n.ad_oe   = 1'b1;
                    if (r.nmi_pend) begin
                        n.status   = `CBSC_ST_ACK_UNMASK;
                        n.nmi_pend = nmi_edge;
                    end else if (r.flag_control_word[`CBSC_FCW_VIE] && !vectored_irq_n) begin
                        n.status = `CBSC_ST_ACK_VECT;
                    end else begin
                        n.status = `CBSC_ST_ACK_PLAIN;
                    end
                end else if (r.cmd_pend && (r.cmd_code != `CBSC_ST_FETCH_1ST
                             || single_step_n || r.step_tok)) begin
                    n.st     = CBSC_T1;
                    n.status = r.cmd_code;
                    n.as_n   = 1'b0;
                    n.memory_request_n_n = !cbsc_is_mem(r.cmd_code);
                    n.dir    = r.cmd_read;
                    n.bw     = r.cmd_byte;
                    n.ad_oe  = 1'b1;
                    if (r.cmd_code == `CBSC_ST_MEM_STACK) begin
                        n.ad_out = word_rd(r, (r.sp_sel == 4'h0) ? 4'hF : r.sp_sel);
                    end else begin
                        n.ad_out = r.addr;
                    end
                    if (r.cmd_code == `CBSC_ST_FETCH_1ST && !single_step_n) begin
                        n.step_tok = r.step_prev && !single_step_n;
                    end
                end
            end
            CBSC_T1: begin
                n.as_n = 1'b1;
                n.st   = CBSC_T2;
                if (r.cyc_ack || !no_wait) begin
                    n.ds_n = 1'b0;
                end
                if (r.cyc_ack || r.dir || no_wait) begin
                    n.ad_oe = 1'b0;
                end else begin
                    n.ad_out = r.wdata;
                end
            end
            CBSC_T2: begin
                if (!r.cyc_ack && is_io) begin
                    n.st = CBSC_TWA;
                end else if (!r.cyc_ack && no_wait) begin
                    n.st = CBSC_T3;
                end else begin
                    n.st = wait_n ? CBSC_T3 : CBSC_TW;
                end
            end
            CBSC_TWA: begin
                n.st = wait_n ? CBSC_T3 : CBSC_TW;
            end
            CBSC_TW: begin
                n.st = wait_n ? CBSC_T3 : CBSC_TW;
            end
            CBSC_T3: begin
                n.st     = CBSC_IDLE;
                n.ds_n   = 1'b1;
                n.memory_request_n_n = 1'b1;
                n.ad_oe  = 1'b0;
                if (r.cyc_ack) begin
                    n.ack_vec = addr_data_in;
                end else begin
                    n.cmd_pend = 1'b0;
                    if (r.dir && !no_wait) begin
                        n.rdata = addr_data_in;
                    end
                end
            end
            CBSC_GRANT: begin
                if (r.brq_s2) begin
                    n.st = CBSC_RELEASE;
                end
            end
            CBSC_RELEASE: begin
                n.st      = CBSC_IDLE;
                n.grant_n = 1'b1;
                n.ctl_oe  = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // state register
    // ==========================================================
    // synchronous reset restarts everything
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            r          <= '0;
            r.st       <= CBSC_IDLE;
            r.flag_control_word      <= `CBSC_FCW_RESET;
            r.brq_s1   <= 1'b1;
            r.brq_s2   <= 1'b1;
            r.nmi_prev <= 1'b1;
            r.step_prev <= 1'b1;
            r.status   <= `CBSC_ST_INTERNAL;
            r.as_n     <= 1'b1;
            r.ds_n     <= 1'b1;
            r.memory_request_n_n   <= 1'b1;
            r.dir      <= 1'b1;
            r.ctl_oe   <= 1'b1;
            r.grant_n  <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // outputs straight from flops
    assign prdata           = r.prdata;
    assign pready           = r.pready;
    assign pslverr          = r.pslverr;
    assign addr_data_out    = r.ad_out;
    assign addr_data_oe     = r.ad_oe;
    assign bus_ctl_oe       = r.ctl_oe;
    assign status_code      = r.status;
    assign addr_strobe_n    = r.as_n;
    assign data_strobe_n    = r.ds_n;
    assign memory_request_n = r.memory_request_n_n;
    assign mode_indicator   = r.mode;
    assign byte_word_sel    = r.bw;
    assign direction        = r.dir;
    assign bus_grant_n      = r.grant_n;

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_status_legal: assert property (!cbsc_is_reserved(status_code))
        else $error("reserved status code driven");
    a_grant_boundary: assert property ($fell(bus_grant_n) |-> $past(r.st) == CBSC_IDLE)
        else $error("bus granted inside a machine cycle");
    a_grant_float: assert property (!bus_grant_n |-> !bus_ctl_oe && !addr_data_oe)
        else $error("bus lines driven while granted");
    a_grant_sync: assert property ($fell(bus_grant_n) |-> !$past(r.brq_s2))
        else $error("grant without synchronised request");
    a_memory_request_n_match: assert property (r.st inside {CBSC_T1, CBSC_T2, CBSC_TW, CBSC_TWA}
        |-> memory_request_n == (r.cyc_ack || !cbsc_is_mem(status_code)))
        else $error("memory request disagrees with cycle type");
    a_mode_follow: assert property (##1 mode_indicator == !$past(r.flag_control_word[`CBSC_FCW_SYS]))
        else $error("mode output does not follow control word");
    a_strobe_start: assert property (r.st == CBSC_T1 |-> !addr_strobe_n ##1 addr_strobe_n)
        else $error("machine cycle without one-cycle address strobe");
    a_io_auto: assert property (r.st == CBSC_T2 && !r.cyc_ack && status_code[3:1] == 3'b001
        |=> r.st == CBSC_TWA)
        else $error("I/O cycle missing automatic wait state");
    a_wait_ignore: assert property (r.st == CBSC_T2 && !r.cyc_ack && status_code[3:1] == 3'b000
        |=> r.st == CBSC_T3)
        else $error("wait honoured in internal or refresh cycle");
    a_wait_hold: assert property (r.st inside {CBSC_TW, CBSC_TWA} && !wait_n |=> r.st == CBSC_TW)
        else $error("low wait did not extend the cycle");
    a_release_late: assert property ($rose(bus_grant_n) |-> $past(r.brq_s2, 2))
        else $error("grant released while request still held");
endmodule

// ===== verif/cbsc_far_model.sv
`timescale 1ns/10ps
module cbsc_far_model
    import cbsc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [3:0]  slow,
    input  wire logic        raise,
    input  wire logic        want_bus,
    input  wire logic        addr_strobe_n,
    input  wire logic        data_strobe_n,
    input  wire logic        direction,
    input  wire logic [3:0]  status_code,
    input  wire logic [15:0] addr_data_out,
    output logic             wait_n,
    output logic [15:0]      addr_data_in,
    output logic             bus_request_n,
    output logic             vectored_irq_n,
    output logic             plain_irq_n
);
    logic [3:0]  cnt_q;
    logic [15:0] adr_q;
    // stretch every cycle by slow clocks, latch address
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
        end else if (!addr_strobe_n) begin
            cnt_q <= slow;
            adr_q <= addr_data_out;
        end else if (!data_strobe_n && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    assign wait_n = (cnt_q == 4'h0);
    // data only while read strobe is low, inverse otherwise
    assign addr_data_in = (!data_strobe_n && direction) ? adr_q ^ 16'h5A5A : ~(adr_q ^ 16'h5A5A);
    // lines stay low until their acknowledge shows
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            vectored_irq_n <= 1'b1;
            plain_irq_n <= 1'b1;
        end else if (raise) begin
            vectored_irq_n <= 1'b0;
            plain_irq_n <= 1'b0;
        end else if (!addr_strobe_n) begin
            vectored_irq_n <= vectored_irq_n | (status_code == 4'h7);
            plain_irq_n <= plain_irq_n | (status_code == 4'h6);
        end
    end
    // borrowed lines are never driven, so release is clean
    assign bus_request_n = !want_bus;
endmodule

// ===== verif/cpu_bus_status_control_tb_top.sv
`timescale 1ns/10ps
module cpu_bus_status_control_tb_top
    import cbsc_pkg::*;
;
    logic        clock, pready, pslverr, er, addr_data_oe, bus_ctl_oe, addr_strobe_n;
    logic        data_strobe_n, memory_request_n, mode_indicator, byte_word_sel, direction;
    logic        bus_grant_n, wait_n, bus_request_n, vectored_irq_n, plain_irq_n;
    logic        rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, raise = 1'b0;
    logic        single_step_n = 1'b1, unmaskable_irq_n = 1'b1, want_bus = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] addr_data_in, addr_data_out;
    logic [3:0]  status_code, slow = 4'h0;
    logic [3:0]  codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hC, 4'hD};
    int          num_errors = 0, compares = 0, n_as = 0, n_ds = 0, n_mr = 0, a0;
    cbsc_core i_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .wait_n, .bus_request_n, .unmaskable_irq_n, .vectored_irq_n,
        .plain_irq_n, .single_step_n, .addr_data_in, .addr_data_out, .addr_data_oe,
        .bus_ctl_oe, .status_code, .addr_strobe_n, .data_strobe_n, .memory_request_n,
        .mode_indicator, .byte_word_sel, .direction, .bus_grant_n);
    cbsc_far_model i_far (.clock, .rst_n, .slow, .raise, .want_bus, .addr_strobe_n,
        .data_strobe_n, .direction, .status_code, .addr_data_out, .wait_n, .addr_data_in,
        .bus_request_n, .vectored_irq_n, .plain_irq_n);
    // =====
    // clock and strobe counters
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        n_as += !addr_strobe_n;
        n_ds += !data_strobe_n;
        n_mr += !memory_request_n;
    end
    // =====
    // checking and bus tasks
    task automatic wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic hang(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            wrap_up();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        hang(n, 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_code(input logic [3:0] c);
        int n;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (addr_strobe_n === 1'b0) break;
        end
        chk(status_code, c);
        hang(n, 100);
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 20; n++) begin
            apb(1'b0, 12'h004, 32'h0);
            if (rd[1] === 1'b0) break;
        end
        hang(n, 20);
    endtask
    task automatic run(input logic [3:0] c);
        int d0, m0;
        slow <= (c[3] || c < 4'h2) ? 4'h2 : 4'h0;
        apb(1'b1, 12'h008, {16'h0, 8'h3C, c, 4'h0});
        d0 = n_ds;
        m0 = n_mr;
        apb(1'b1, 12'h004, {27'h0, 1'b1, c});
        wait_code(c);
        wait_idle();
        chk(n_mr - m0, (c == 4'h1) ? 3 : c[3] ? 5 : 0);
        chk(n_ds - d0, c[3] ? 4 : c[1] ? 3 : 0);
        if (c == 4'h8 || c[2]) begin
            apb(1'b0, 12'h010, 32'h0);
            chk(rd, {16'h0, 8'h3C, c, 4'h0} ^ 32'h5A5A);
        end
    endtask
    // =====
    // main sequence
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h4000);
        apb(1'b1, 12'h000, 32'hFFFF);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h58FC);
        apb(1'b1, 12'h000, 32'h0);
        repeat (2) @(posedge clock);
        chk(mode_indicator, 1'b1);
        apb(1'b1, 12'h000, 32'h4000);
        repeat (2) @(posedge clock);
        chk(mode_indicator, 1'b0);
        apb(1'b1, 12'h07C, 32'hBEEF);
        apb(1'b0, 12'h080, 32'h0);
        chk(rd, 32'hBEEF);
        apb(1'b0, 12'h084, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h040, 32'h1234);
        apb(1'b1, 12'h044, 32'h5678);
        apb(1'b0, 12'h100, 32'h0);
        chk(rd, 32'h12345678);
        apb(1'b0, 12'h0C0, 32'h0);
        chk(rd, 32'h12);
        apb(1'b0, 12'hFFC, 32'h0);
        chk(er, 1'b1);
        foreach (codes[i]) run(codes[i]);
        single_step_n <= 1'b0;
        run(4'hD);
        a0 = n_as;
        apb(1'b1, 12'h004, 32'h1D);
        repeat (20) @(posedge clock);
        chk(n_as - a0, 0);
        single_step_n <= 1'b1;
        @(posedge clock);
        single_step_n <= 1'b0;
        wait_code(4'hD);
        wait_idle();
        single_step_n <= 1'b1;
        raise <= 1'b1;
        @(posedge clock);
        raise <= 1'b0;
        a0 = n_as;
        repeat (30) @(posedge clock);
        chk(n_as - a0, 0);
        unmaskable_irq_n <= 1'b0;
        wait_code(4'h5);
        apb(1'b1, 12'h000, 32'h5800);
        wait_code(4'h7);
        wait_code(4'h6);
        unmaskable_irq_n <= 1'b1;
        wait_idle();
        repeat (10) @(posedge clock);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h3CD0 ^ 32'h5A5A);
        a0 = n_as;
        apb(1'b1, 12'h004, 32'h14);
        repeat (20) @(posedge clock);
        apb(1'b0, 12'h004, 32'h0);
        chk({rd[2], n_as - a0}, {1'b1, 32'h0});
        want_bus <= 1'b1;
        for (a0 = 0; a0 < 30 && bus_grant_n !== 1'b0; a0++) @(posedge clock);
        chk({bus_grant_n, bus_ctl_oe, addr_data_oe}, 3'b000);
        want_bus <= 1'b0;
        for (a0 = 0; a0 < 30 && bus_grant_n !== 1'b1; a0++) @(posedge clock);
        @(posedge clock);
        chk({bus_grant_n, bus_ctl_oe}, 2'b11);
        wrap_up();
    end
endmodule
